// ===== mts_pkg.sv
// package of constants and carrier types for the meter trigger sequencer
package mts_pkg;
   // trigger source encodings
   localparam logic [2:0] MTS_SRC_INTERNAL = 3'h0;
   localparam logic [2:0] MTS_SRC_GROUP    = 3'h1;
   localparam logic [2:0] MTS_SRC_EXTERNAL = 3'h2;
   localparam logic [2:0] MTS_SRC_HOLD     = 3'h3;
   localparam logic [2:0] MTS_SRC_LINE     = 3'h4;

   // register offsets (byte addresses)
   localparam logic [7:0] MTS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] MTS_OFF_TCOUNT = 8'h04;
   localparam logic [7:0] MTS_OFF_SCOUNT = 8'h08;
   localparam logic [7:0] MTS_OFF_CMD    = 8'h0c;
   localparam logic [7:0] MTS_OFF_STATUS = 8'h10;
   localparam logic [7:0] MTS_OFF_TDONE  = 8'h14;
   localparam logic [7:0] MTS_OFF_RDCNT  = 8'h18;
   localparam logic [7:0] MTS_OFF_RDATA  = 8'h1c;

   // command register bits
   localparam int MTS_CMD_INIT    = 0;
   localparam int MTS_CMD_IMMED   = 1;
   localparam int MTS_CMD_COMMON  = 2;
   localparam int MTS_CMD_COMMAND_A = 3;
   localparam int MTS_CMD_CONFIG  = 4;
   localparam int MTS_CMD_ABORT   = 5;

   // reset values and largest count
   localparam logic [23:0] MTS_TCOUNT_RST = 24'h000001;
   localparam logic [23:0] MTS_SCOUNT_RST = 24'h000001;
   localparam logic [23:0] MTS_COUNT_MAX  = 24'hffffff;

   // buffer geometry
   localparam int MTS_BUF_DEPTH       = 512;
   localparam int MTS_BUF_DEPTH_SLOW  = 256;
   localparam int MTS_BUF_WIDTH       = 16;

   // sample loop rate: about 13 k samples per second at 40 MHz
   localparam int MTS_CLK_HZ        = 40000000;
   localparam int MTS_SAMPLE_HZ     = 13000;
   localparam int MTS_SAMPLE_CYCLES = MTS_CLK_HZ / MTS_SAMPLE_HZ;

   // offset compensation limit: ten percent of full induced voltage
   localparam int MTS_OCOMP_PCT = 10;

   typedef enum logic [2:0] {
      MTS_IDLE = 3'b001,
      MTS_WAIT = 3'b010,
      MTS_TRIG = 3'b100
   } mts_state_type;

   // measurement request to the converter front end
   typedef struct packed {
      logic        start;
      logic        source_on;
      logic        connect_ext;
      logic        autozero;
   } mts_conv_req_type;

   // converter result
   typedef struct packed {
      logic        done;
      logic [15:0] value;
   } mts_conv_res_type;
endpackage : mts_pkg

// ===== mts_sequencer.sv
// trigger and measurement sequencer with apb registers and reading buffer
//
// Contract
// - three states idle, waiting for trigger, triggered; moves only as conditions allow.
// - configuration and trigger settings are written only while idle.
// - a selected-source trigger while waiting enters triggered and starts a measurement.
// - one measurement per trigger and count one returns to idle at completion.
// - multiple samples or triggers keep the block busy until all are done.
// - outer trigger loop encloses inner sample loop paced near 13k samples/s with autozero off, half that with autozero on.
// - readings stored in a 512 by 16 bit buffer.
// - buffer holds 512 readings in fast aperture mode, 256 otherwise.
// - group source fires on common command or group execute if last listener.
// - external source fires on a falling edge of the external input.
// - hold source ignores everything except the internal_always_source trigger command.
// - internal source triggers at once on entering wait.
// - command_a and configure select internal source; command_a also starts waiting.
// - eight backplane trigger lines 0..7 selectable, only on backplane variant.
// - received triggers are counted; idle once programmed count is reached.
// - offset compensated reading: source on, source off, difference over current; diff_value carries the difference unscaled.
// - offset phase keeps the external circuit connected.
// - compensation overrides autozero; rate follows autozero setting.
// - compensation is an on/off setting forced off by command_a and configure.
// - compensation range covers offsets up to ten percent of induced voltage.
// - trigger count accepts 1 to 16777215 in a 24-bit counter.
// - in scanning each trigger starts one pass; count sets passes.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module mts_sequencer
   import mts_pkg::*;
#(
   parameter bit BACKPLANE    = 1'b1,
   parameter int SAMPLE_CYCLES = MTS_SAMPLE_CYCLES
)(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   input  wire logic             group_execute,
   input  wire logic             last_listener,
   input  wire logic             ext_trig_in,
   input  wire logic [7:0]       backplane_lines,
   input  wire mts_conv_res_type conv_res,
   input  wire logic [15:0]      ocomp_result,
   output mts_conv_req_type      conv_req,
   output logic [15:0]           diff_value,
   output logic                  diff_valid,
   output logic [2:0]            seq_state
);
   // sequencer state and trigger settings
   mts_state_type     state_r;
   logic [2:0]        src_r;
   logic [2:0]        line_sel_r;
   logic              ocomp_r;
   logic              autozero_r;
   logic              fast_ap_r;

   // programmed and completed loop counts
   logic [23:0]       tcount_r;
   logic [23:0]       scount_r;
   logic [23:0]       tdone_r;
   logic [23:0]       sdone_r;

   // sample pacing and trigger edge history
   logic [15:0]       pace_r;
   logic              ext_d_r;
   logic              line_d_r;

   // converter phasing
   logic              phase_off_r;
   logic              busy_conv_r;
   logic [15:0]       on_val_r;

   // reading buffer
   logic [8:0]        wr_ptr_r;
   logic [8:0]        rd_ptr_r;
   logic [9:0]        fill_r;
   logic [MTS_BUF_WIDTH-1:0] buf_mem [MTS_BUF_DEPTH];

   // bus strobes, decoded commands and loop events
   logic wr_en, rd_en, idle, pop_en, conv_go;
   logic cmd_init, cmd_immed, cmd_common, cmd_command_a, cmd_config, cmd_abort;
   logic trig_hit, meas_done, sample_end, reading_ok;
   logic [9:0] buf_cap;

   // apb decode; zero wait states
   // reads have no side effect except the data register pop
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign idle    = (state_r == MTS_IDLE);

   // command strobes from the write-only command word
   assign cmd_init    = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_INIT];
   assign cmd_immed   = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_IMMED];
   assign cmd_common  = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_COMMON];
   assign cmd_command_a = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_COMMAND_A];
   assign cmd_config  = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_CONFIG];
   assign cmd_abort   = wr_en & (paddr == MTS_OFF_CMD) & pwdata[MTS_CMD_ABORT];

   // trigger source selection
   // edges or lines of an unselected source never fire
   always_comb begin
      trig_hit = 1'b0;
      case (src_r)
         MTS_SRC_INTERNAL: trig_hit = 1'b1;
         // common command or group execute when last listener
         MTS_SRC_GROUP:    trig_hit = cmd_common | (group_execute & last_listener);
         MTS_SRC_EXTERNAL: trig_hit = ext_d_r & ~ext_trig_in;
         MTS_SRC_LINE:     trig_hit = BACKPLANE & line_d_r & ~backplane_lines[line_sel_r];
         MTS_SRC_HOLD:     trig_hit = 1'b0;
         default:          trig_hit = 1'b0;
      endcase
      // internal_always_source command fires any source, the only way out of hold
      if (cmd_immed) begin
         trig_hit = 1'b1;
      end
   end

   // edge history for external and backplane inputs
   // a new line selection can look like an edge; it changes only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_d_r  <= 1'b1;
         line_d_r <= 1'b1;
      end else begin
         ext_d_r  <= ext_trig_in;
         line_d_r <= backplane_lines[line_sel_r];
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_r      <= MTS_SRC_INTERNAL;
         line_sel_r <= 3'h0;
         ocomp_r    <= 1'b0;
         autozero_r <= 1'b1;
         fast_ap_r  <= 1'b0;
      end else if (idle) begin
         // command_a and configure force internal source, no compensation
         if (cmd_command_a | cmd_config) begin
            src_r    <= MTS_SRC_INTERNAL;
            ocomp_r  <= 1'b0;
            autozero_r <= 1'b1;
         end else if (wr_en && paddr == MTS_OFF_CTRL) begin
            // backplane lines refused on the front-panel variant
            if (pwdata[2:0] != MTS_SRC_LINE || BACKPLANE) begin
               src_r <= pwdata[2:0];
            end
            line_sel_r <= pwdata[6:4];
            ocomp_r    <= pwdata[8];
            autozero_r <= pwdata[9];
            fast_ap_r  <= pwdata[10];
         end
      end
   end

   // loop counts; zero is clamped so that every loop runs at least once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcount_r <= MTS_TCOUNT_RST;
         scount_r <= MTS_SCOUNT_RST;
      end else if (idle) begin
         if (cmd_command_a | cmd_config) begin
            // command_a and configure restore a count of one
            tcount_r <= MTS_TCOUNT_RST;
         end else if (wr_en && paddr == MTS_OFF_TCOUNT) begin
            tcount_r <= (pwdata[23:0] == 24'h000000) ? MTS_TCOUNT_RST : pwdata[23:0];
         end else if (wr_en && paddr == MTS_OFF_SCOUNT) begin
            scount_r <= (pwdata[23:0] == 24'h000000) ? MTS_SCOUNT_RST : pwdata[23:0];
         end
      end
   end

   // sample pacing: a sample may start only when the pace counter is zero
   // trade-off: spacing runs from each start, so a slow converter sets the pace
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pace_r <= 16'h0000;
      end else if (conv_req.start) begin
         // inner loop spacing; autozero doubles it
         pace_r <= autozero_r ? 16'(2 * SAMPLE_CYCLES) : 16'(SAMPLE_CYCLES);
      end else if (pace_r != 16'h0000) begin
         pace_r <= pace_r - 16'h0001;
      end
   end

   // a reading is complete when the converter finishes its last phase
   // without compensation the first conversion is the whole reading
   assign meas_done  = conv_res.done & busy_conv_r & (~ocomp_r | phase_off_r);
   assign sample_end = meas_done & (sdone_r + 24'h000001 >= scount_r);

   // a conversion begins only while triggered and not being aborted
   assign conv_go = (state_r == MTS_TRIG) & ~cmd_abort & ~busy_conv_r
                    & (pace_r == 16'h0000) & ~conv_req.start;

   // converter phasing and offset compensated difference
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_conv_r <= 1'b0;
         phase_off_r <= 1'b0;
         on_val_r    <= 16'h0000;
         conv_req    <= '0;
      end else begin
         conv_req.start <= 1'b0;
         if (conv_go) begin
            busy_conv_r          <= 1'b1;
            conv_req.start       <= 1'b1;
            // first phase with current source on
            conv_req.source_on   <= 1'b1;
            conv_req.connect_ext <= 1'b1;
            conv_req.autozero    <= autozero_r & ~ocomp_r;
            phase_off_r          <= 1'b0;
         end else if (conv_res.done && busy_conv_r) begin
            // an abort drops the offset phase so nothing starts while idle
            if (ocomp_r && !phase_off_r && state_r == MTS_TRIG && !cmd_abort) begin
               on_val_r             <= conv_res.value;
               phase_off_r          <= 1'b1;
               conv_req.start       <= 1'b1;
               conv_req.source_on   <= 1'b0;
               // external circuit stays connected during offset phase
               conv_req.connect_ext <= 1'b1;
            end else begin
               busy_conv_r <= 1'b0;
               phase_off_r <= 1'b0;
            end
         end
      end
   end

   // difference output; scaling by current done downstream
   // offsets up to ten percent of full scale fit in the difference
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diff_value <= 16'h0000;
         diff_valid <= 1'b0;
      end else begin
         diff_valid <= meas_done;
         if (meas_done) begin
            diff_value <= ocomp_r ? on_val_r - conv_res.value : conv_res.value;
         end
      end
   end

   // main state machine and loop counters
   // three-state trigger sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= MTS_IDLE;
         tdone_r <= 24'h000000;
         sdone_r <= 24'h000000;
      end else begin
         case (state_r)
            MTS_IDLE: begin
               if (cmd_init | cmd_command_a) begin
                  state_r <= MTS_WAIT;
                  tdone_r <= 24'h000000;
                  sdone_r <= 24'h000000;
               end
            end
            MTS_WAIT: begin
               if (cmd_abort) begin
                  state_r <= MTS_IDLE;
               end else if (trig_hit) begin
                  state_r <= MTS_TRIG;
                  sdone_r <= 24'h000000;
               end
            end
            MTS_TRIG: begin
               if (cmd_abort) begin
                  state_r <= MTS_IDLE;
               end else if (sample_end) begin
                  // outer loop counts triggers or passes
                  tdone_r <= tdone_r + 24'h000001;
                  // idle only when all counts are satisfied
                  if (tdone_r + 24'h000001 >= tcount_r) begin
                     state_r <= MTS_IDLE;
                  end else begin
                     state_r <= MTS_WAIT;
                  end
               end else if (meas_done) begin
                  sdone_r <= sdone_r + 24'h000001;
               end
            end
            default: state_r <= MTS_IDLE;
         endcase
      end
   end

   assign buf_cap    = fast_ap_r ? 10'(MTS_BUF_DEPTH) : 10'(MTS_BUF_DEPTH_SLOW);
   assign reading_ok = diff_valid & (fill_r < buf_cap);

   // reading buffer; readings beyond capacity are dropped
   always_ff @(posedge pclk) begin
      if (reading_ok) begin
         buf_mem[wr_ptr_r] <= diff_value;
      end
   end

   // a read of the data register pops one reading; an empty buffer is not popped
   assign pop_en = rd_en & (paddr == MTS_OFF_RDATA) & (fill_r != 10'h000);

   // buffer pointers; init and command_a start a fresh buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= 9'h000;
         rd_ptr_r <= 9'h000;
      end else if (cmd_init | cmd_command_a) begin
         wr_ptr_r <= 9'h000;
         rd_ptr_r <= 9'h000;
      end else begin
         if (reading_ok) begin
            wr_ptr_r <= wr_ptr_r + 9'h001;
         end
         if (pop_en) begin
            rd_ptr_r <= rd_ptr_r + 9'h001;
         end
      end
   end

   // fill level; a reading that lands with a pop leaves it unchanged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_r <= 10'h000;
      end else if (cmd_init | cmd_command_a) begin
         fill_r <= 10'h000;
      end else begin
         fill_r <= fill_r + 10'(reading_ok) - 10'(pop_en);
      end
   end

   // read mux; unmapped addresses read zero
   // the data word shows the oldest reading, stale when the buffer is empty
   always_comb begin
      case (paddr)
         MTS_OFF_CTRL:   prdata = {21'h000000, fast_ap_r, autozero_r, ocomp_r, 1'b0,
                                   line_sel_r, 1'b0, src_r};
         MTS_OFF_TCOUNT: prdata = {8'h00, tcount_r};
         MTS_OFF_SCOUNT: prdata = {8'h00, scount_r};
         MTS_OFF_STATUS: prdata = {29'h00000000, state_r};
         MTS_OFF_TDONE:  prdata = {8'h00, tdone_r};
         MTS_OFF_RDCNT:  prdata = {22'h000000, fill_r};
         MTS_OFF_RDATA:  prdata = {16'h0000, buf_mem[rd_ptr_r]};
         default:        prdata = 32'h00000000;
      endcase
   end

   // state is exported for status and the checker
   assign seq_state = state_r;
endmodule : mts_sequencer

// ===== mts_conv_model.sv
// converter front-end model that answers the sequencer's start requests
`timescale 1ns/100ps
module mts_conv_model
   import mts_pkg::*;
#(
   parameter logic [15:0] VON  = 16'h1234,
   parameter logic [15:0] VOFF = 16'h0034
)(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             slow,
   input  wire mts_conv_req_type conv_req,
   output mts_conv_res_type      conv_res
);
   logic [3:0] cnt_r;
   logic       on_r;

   // answer after two or twelve cycles; value toggles when not valid so stale data never looks good
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= 4'h0;
         on_r     <= 1'b0;
         conv_res <= '0;
      end else begin
         conv_res.done  <= 1'b0;
         conv_res.value <= ~conv_res.value;
         if (conv_req.start) begin
            cnt_r <= slow ? 4'hc : 4'h2;
            on_r  <= conv_req.source_on;
         end else if (cnt_r == 4'h1) begin
            cnt_r         <= 4'h0;
            conv_res.done <= 1'b1;
            conv_res.value <= on_r ? VON : VOFF;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule : mts_conv_model

// ===== mts_sequencer_assertions.sv
// port-level checker for the sequencer
`timescale 1ns/100ps
module mts_chk
   import mts_pkg::*;
(
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire mts_conv_res_type conv_res,
   input wire mts_conv_req_type conv_req,
   input wire logic             diff_valid,
   input wire logic [2:0]       seq_state
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // state machine, converter handshake and bus answer relations
   state_onehot_a: assert property ($onehot(seq_state))
      else $error("state not one-hot");
   idle_no_skip_a: assert property (seq_state == 3'b001 |=> seq_state != 3'b100)
      else $error("idle jumped straight to triggered");
   start_in_trig_a: assert property (conv_req.start |-> seq_state == 3'b100)
      else $error("conversion started outside triggered");
   start_space_a: assert property (conv_req.start |=> !conv_req.start [*3])
      else $error("conversion starts too close");
   diff_after_done_a: assert property (diff_valid |-> $past(conv_res.done))
      else $error("reading without a finished conversion");
   off_after_done_a: assert property (conv_req.start && !conv_req.source_on |-> $past(conv_res.done))
      else $error("offset phase not right after first conversion");
   offset_connect_a: assert property (conv_req.start && !conv_req.source_on |-> conv_req.connect_ext)
      else $error("offset phase detached the circuit");
   diff_pulse_a: assert property (diff_valid |=> !diff_valid)
      else $error("reading strobe longer than one cycle");
   zero_wait_a: assert property (pready && !pslverr)
      else $error("bus answer not ready or error");

   // main scenarios reached
   cover property (diff_valid);
   cover property (conv_req.start && !conv_req.source_on);
   cover property (seq_state == 3'b010 ##1 seq_state == 3'b100);
endmodule : mts_chk

bind mts_sequencer mts_chk chk (.pclk, .presetn, .pready, .pslverr, .conv_res, .conv_req,
   .diff_valid, .seq_state);

// ===== tb_meter_trigger_sequencer.sv
// self-checking bench for the meter trigger sequencer
`timescale 1ns/100ps
module tb_meter_trigger_sequencer
   import mts_pkg::*;
;
   localparam logic [15:0] VON  = 16'h1234;
   localparam logic [15:0] VOFF = 16'h0034;
   typedef struct packed {
      logic [2:0] src;
      logic [2:0] ln;
      logic [2:0] kind;
      logic [2:0] st;
   } mts_row_type;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
   logic             group_execute, last_listener, ext_trig_in, diff_valid;
   logic [7:0]       paddr, backplane_lines;
   logic [31:0]      pwdata, prdata, q;
   logic [15:0]      diff_value;
   logic [2:0]       seq_state;
   mts_conv_req_type conv_req;
   mts_conv_res_type conv_res;
   int               n_errors, comparisons;
   // kinds: 0 none, 1 common cmd, 2 group exec listener, 3 without, 4 ext fall, 5 internal_always_source, 6 line
   // trigger source rows for all five sources
   mts_row_type rows [11] = '{
      '{MTS_SRC_INTERNAL, 3'h0, 3'h0, 3'h1}, '{MTS_SRC_GROUP, 3'h0, 3'h1, 3'h1},
      '{MTS_SRC_GROUP, 3'h0, 3'h2, 3'h1}, '{MTS_SRC_GROUP, 3'h0, 3'h3, 3'h2},
      '{MTS_SRC_EXTERNAL, 3'h0, 3'h4, 3'h1}, '{MTS_SRC_EXTERNAL, 3'h0, 3'h2, 3'h2},
      '{MTS_SRC_HOLD, 3'h0, 3'h1, 3'h2}, '{MTS_SRC_HOLD, 3'h0, 3'h4, 3'h2},
      '{MTS_SRC_HOLD, 3'h0, 3'h5, 3'h1}, '{MTS_SRC_LINE, 3'h5, 3'h6, 3'h1},
      '{MTS_SRC_LINE, 3'h2, 3'h6, 3'h2}};

   mts_sequencer #(.SAMPLE_CYCLES(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .group_execute, .last_listener, .ext_trig_in,
      .backplane_lines, .conv_res, .ocomp_result(16'h0000), .conv_req, .diff_value,
      .diff_valid, .seq_state);
   mts_conv_model #(.VON(VON), .VOFF(VOFF)) conv (.pclk, .presetn, .slow, .conv_req, .conv_res);

   // free-running clock, 25 ns period
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // one apb transfer; the request is held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // raise one trigger event of the given kind; edges idle high like ttl lines
   task automatic fire(input logic [2:0] kind, input logic [2:0] ln);
      case (kind)
         3'h1: apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_COMMON);
         3'h2, 3'h3: begin
            last_listener <= (kind == 3'h2);
            group_execute <= 1'b1;
            @(posedge pclk);
            group_execute <= 1'b0;
         end
         3'h4: begin
            ext_trig_in <= 1'b0;
            repeat (2) @(posedge pclk);
            ext_trig_in <= 1'b1;
         end
         3'h5: apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_IMMED);
         3'h6: begin
            backplane_lines[ln] <= 1'b0;
            repeat (2) @(posedge pclk);
            backplane_lines[ln] <= 1'b1;
         end
         default: ;
      endcase
   endtask : fire

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // watchdog far beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      tally_and_finish();
   end

   // main sequence
   initial begin
      {presetn, psel, penable, pwrite, slow, group_execute, last_listener} = 7'h00;
      {paddr, pwdata, ext_trig_in, backplane_lines} = {8'h00, 32'h0, 1'b1, 8'hff};
      n_errors = 0;
      comparisons = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, MTS_OFF_CTRL, {29'h0000004a, rows[i].src});
         apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_INIT);
         fire(rows[i].kind, rows[i].ln);
         repeat (30) @(posedge pclk);
         apb(1'b0, MTS_OFF_STATUS, 32'h0);
         chk(q, {29'h0, rows[i].st}, "source row");
         apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_ABORT);
         $display("test source row %0d done", i);
      end
      // three triggers of two compensated samples, slow converter; count write refused
      slow <= 1'b1;
      apb(1'b1, MTS_OFF_TCOUNT, 32'h3);
      apb(1'b1, MTS_OFF_SCOUNT, 32'h2);
      apb(1'b1, MTS_OFF_CTRL, 32'h00000303);
      apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_INIT);
      apb(1'b1, MTS_OFF_TCOUNT, 32'h1);
      for (int t = 1; t <= 3; t++) begin
         fire(3'h5, 3'h0);
         repeat (150) @(posedge pclk);
         apb(1'b0, MTS_OFF_STATUS, 32'h0);
         chk(q, (t == 3) ? 32'h1 : 32'h2, "loop state");
      end
      apb(1'b0, MTS_OFF_TDONE, 32'h0);
      chk(q, 32'h3, "triggers done");
      apb(1'b0, MTS_OFF_RDCNT, 32'h0);
      chk(q, 32'h6, "readings stored");
      apb(1'b0, MTS_OFF_RDATA, 32'h0);
      chk({16'h0, q[15:0]}, {16'h0, VON - VOFF}, "compensated value");
      $display("test loops done");
      // command_a and configure restore internal source, count one, compensation off
      slow <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, MTS_OFF_CTRL, 32'h00000303);
         apb(1'b1, MTS_OFF_TCOUNT, 32'h5);
         apb(1'b1, MTS_OFF_CMD, 32'h1 << (m == 0 ? MTS_CMD_COMMAND_A : MTS_CMD_CONFIG));
         repeat (40) @(posedge pclk);
         apb(1'b0, MTS_OFF_STATUS, 32'h0);
         chk(q, 32'h1, "after command");
         apb(1'b0, MTS_OFF_CTRL, 32'h0);
         chk(q & 32'h00000307, 32'h00000200, "command ctrl");
         apb(1'b0, MTS_OFF_TCOUNT, 32'h0);
         chk(q, 32'h1, "command count");
      end
      apb(1'b0, MTS_OFF_RDCNT, 32'h0);
      chk(q, 32'h2, "command_a reading");
      $display("test commands done");
      // an edge seen while idle must not be remembered
      apb(1'b1, MTS_OFF_CTRL, 32'h00000202);
      fire(3'h4, 3'h0);
      apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_INIT);
      repeat (30) @(posedge pclk);
      apb(1'b0, MTS_OFF_STATUS, 32'h0);
      chk(q, 32'h2, "idle edge");
      // reset while waiting, then defaults and an unmapped read
      presetn <= 1'b0;
      @(posedge pclk);
      chk({29'h0, seq_state}, 32'h1, "state in reset");
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, MTS_OFF_CTRL, 32'h0);
      chk(q & 32'h00000307, 32'h00000200, "reset ctrl");
      apb(1'b0, MTS_OFF_TCOUNT, 32'h0);
      chk(q, 32'h1, "reset count");
      apb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h0, "unmapped read");
      $display("test reset done");
      // fill past the smaller capacity in both aperture modes, autozero off
      apb(1'b1, MTS_OFF_SCOUNT, 32'h12c);
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, MTS_OFF_CTRL, (f == 0) ? 32'h0 : 32'h400);
         apb(1'b1, MTS_OFF_CMD, 32'h1 << MTS_CMD_INIT);
         repeat (2500) @(posedge pclk);
         apb(1'b0, MTS_OFF_RDCNT, 32'h0);
         chk(q, (f == 0) ? 32'h100 : 32'h12c, "buffer capacity");
      end
      $display("test capacity done");
      tally_and_finish();
   end
endmodule : tb_meter_trigger_sequencer
